// *** hdl/riv_consts.svh ***
// riv_consts.svh: register offsets, reset values, field positions and vectors
// for the reset and wake-up initialisation block; definitions only.
`ifndef RIV_CONSTS_SVH
`define RIV_CONSTS_SVH
// apb byte offsets, one aligned word per register
`define RIV_OFF_BANK_SELECT   12'h000
`define RIV_OFF_TMR0_HIGH     12'h004
`define RIV_OFF_TMR0_CTRL     12'h008
`define RIV_OFF_LVD_CTRL      12'h00c
`define RIV_OFF_WDT_SOFT      12'h010
`define RIV_OFF_TMR1_CTRL     12'h014
`define RIV_OFF_TIMER2_COUNT_COUNT    12'h018
`define RIV_OFF_TIMER2_COUNT_PERIOD   12'h01c
`define RIV_OFF_TIMER2_COUNT_CTRL     12'h020
`define RIV_OFF_SSP_ADDR      12'h024
`define RIV_OFF_SSP_STATE     12'h028
`define RIV_OFF_SSP_CTRL1     12'h02c
`define RIV_OFF_SSP_CTRL2     12'h030
`define RIV_OFF_STACK_UPPER   12'h034
`define RIV_OFF_STACK_HIGH    12'h038
`define RIV_OFF_STACK_LOW     12'h03c
`define RIV_OFF_STACK_PTR     12'h040
`define RIV_OFF_INT_CTRL      12'h044
`define RIV_OFF_PERIPH_FLAG   12'h048
`define RIV_OFF_PORT_A_PINS_LATCH   12'h04c
`define RIV_OFF_PORT_A_PINS_DIR     12'h050
`define RIV_OFF_PORT_A_PINS_PINS    12'h054
`define RIV_OFF_RESET_CAUSE   12'h058
`define RIV_OFF_OSC_CTRL      12'h05c
`define RIV_OFF_IRQ_STATUS    12'h060
`define RIV_OFF_IRQ_MASK      12'h064
// reset values
`define RIV_RST_TMR0_CTRL     8'hff
`define RIV_RST_LVD_CTRL      6'h05
`define RIV_RST_TIMER2_COUNT_PERIOD   8'hff
`define RIV_RST_PORT_A_PINS_DIR     8'hff
`define RIV_RST_CAUSE_POR     5'h1c
// reset cause bits: {ri, to, pd, por, bor}
`define RIV_RC_RI             4
`define RIV_RC_TO             3
`define RIV_RC_PD             2
`define RIV_RC_POR            1
`define RIV_RC_BOR            0
// field positions
`define RIV_GIE_HIGH          7
`define RIV_GIE_LOW           6
`define RIV_TMR1_CLR_BIT      6
`define RIV_OSC_COND_BIT      3
`define RIV_PORT_A_PINS_LOW_MASK    8'h3f
// interrupt status bits
`define RIV_IS_WARM           0
`define RIV_IS_WAKE_WDT       1
`define RIV_IS_WAKE_VEC       2
`define RIV_IS_STACK_FULL     3
// interrupt vectors
`define RIV_VEC_HIGH          21'h000008
`define RIV_VEC_LOW           21'h000018
`endif

// *** hdl/riv_pkg.sv ***
// riv_pkg: types of the reset and wake-up initialisation block.
// assumes riv_consts.svh carries all numeric constants.
package riv_pkg;
   typedef enum logic [2:0] {
      RIV_CAUSE_NONE = 3'b000,
      RIV_CAUSE_BOR = 3'b001,
      RIV_CAUSE_PIN = 3'b010,
      RIV_CAUSE_WDT = 3'b011,
      RIV_CAUSE_INSTR = 3'b100,
      RIV_CAUSE_STKF = 3'b101,
      RIV_CAUSE_STKU = 3'b110
   } riv_cause_t;
   typedef struct packed {
      logic [3:0] bank_select;
      logic [7:0] timer0_high_byte;
      logic [7:0] timer0_control;
      logic [5:0] low_voltage_detect_control;
      logic watchdog_soft_enable;
      logic [7:0] timer1_control;
      logic [7:0] timer2_count;
      logic [7:0] timer2_period;
      logic [6:0] timer2_control;
      logic [7:0] sync_serial_addr_baud;
      logic [7:0] sync_serial_state;
      logic [7:0] sync_serial_control_1;
      logic [7:0] sync_serial_control_2;
      logic [4:0] stack_top_upper;
      logic [7:0] stack_top_high;
      logic [7:0] stack_top_low;
      logic stk_full;
      logic stk_unf;
      logic [4:0] stk_ptr;
      logic [7:0] interrupt_control_regs;
      logic [7:0] peripheral_flag_regs;
      logic [7:0] port_a_output_latch;
      logic [7:0] port_a_direction;
      logic [7:0] port_a_pins;
      logic [4:0] reset_cause_register;
      logic [7:0] oscillator_control;
      logic [3:0] irq_status;
      logic [3:0] irq_mask;
      logic cond_load;
      logic [7:0] pin_s1;
      logic [7:0] pin_s2;
      logic [7:0] pin_s3;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic irq;
      logic pc_load_valid;
      logic [20:0] pc_load_value;
      logic [7:0] port_a_out;
      logic [7:0] port_a_oe;
   } riv_state_t;
endpackage

// *** hdl/riv_top.sv ***
// riv_top: reset-class and wake-up initialisation of core special registers,
// reached over apb. assumes reset requests, wake requests and pc come from
// core logic on mclk; port a pins arrive asynchronously.
// Functional notes
// (RL1) interrupt wake sets the causing flag bits in the peripheral flag register
// (RL2) vectored interrupt wake loads pc with 0008h high or 0018h low priority
// (RL3) vectored interrupt wake copies current pc into the three stack-top registers
// (RL4) vectored interrupt wake advances the hardware stack pointer by one
// (RL5) port a bits 6 and 7 work only when the oscillator mode frees them
// (RL6) disabled port a bits 6 and 7 are inert and read zero
// (RL7) unimplemented bits always read zero
// (RL8) reset cause register value depends on the specific reset cause
// (RL9) oscillator condition bit loads the live condition at reset and wake-up
// (RL10) wake-up keeps registers, except timer 2 period reloads all ones
`timescale 1ns/1ps
`include "riv_consts.svh"
module riv_top
   import riv_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic pslverr,
   output logic [31:0] prdata,
   output logic irq,
   input wire logic bor_req,
   input wire logic pin_reset_req,
   input wire logic wdt_reset_req,
   input wire logic reset_instr_req,
   input wire logic stk_full_req,
   input wire logic stk_unf_req,
   input wire logic sleeping,
   input wire logic wake_wdt_req,
   input wire logic wake_irq_req,
   input wire logic wake_irq_high,
   input wire logic [7:0] wake_irq_flags,
   input wire logic [20:0] pc_now,
   input wire logic osc_cond,
   input wire logic osc_frees_port_a_pins_hi,
   input wire logic [7:0] port_a_pin_in,
   output logic pc_load_valid,
   output logic [20:0] pc_load_value,
   output logic [7:0] port_a_out,
   output logic [7:0] port_a_oe
);
   // power-on defaults; also the brown-out class
   function automatic riv_state_t por_values();
      riv_state_t s;
      s = '0;
      s.timer0_control = `RIV_RST_TMR0_CTRL;
      s.low_voltage_detect_control = `RIV_RST_LVD_CTRL;
      s.timer2_period = `RIV_RST_TIMER2_COUNT_PERIOD;
      s.port_a_direction = `RIV_RST_PORT_A_PINS_DIR;
      s.reset_cause_register = `RIV_RST_CAUSE_POR;
      s.cond_load = 1'b1;
      return s;
   endfunction
   localparam riv_state_t POR_ST = por_values();

   riv_state_t st;
   riv_state_t next_st;
   riv_cause_t cause;
   logic [7:0] pa_mask;
   logic wr;
   logic vec_wake;

   // live mask for port a: upper pins exist only when the oscillator frees them
   assign pa_mask = osc_frees_port_a_pins_hi ? 8'hff : `RIV_PORT_A_PINS_LOW_MASK; // RL5 RL6
   assign wr = psel & penable & st.pready & pwrite;
   assign vec_wake = sleeping & wake_irq_req & (st.interrupt_control_regs[`RIV_GIE_HIGH]
      | st.interrupt_control_regs[`RIV_GIE_LOW]);

   // reset cause priority: brown-out dominates, then pin, watchdog, instruction, stack
   always_comb
   begin
      if (bor_req)
         cause = RIV_CAUSE_BOR;
      else if (pin_reset_req)
         cause = RIV_CAUSE_PIN;
      else if (wdt_reset_req)
         cause = RIV_CAUSE_WDT;
      else if (reset_instr_req)
         cause = RIV_CAUSE_INSTR;
      else if (stk_full_req)
         cause = RIV_CAUSE_STKF;
      else if (stk_unf_req)
         cause = RIV_CAUSE_STKU;
      else
         cause = RIV_CAUSE_NONE;
   end

   always_comb
   begin
      next_st = st;
      next_st.pc_load_valid = 1'b0;
      next_st.cond_load = 1'b0;
      // pin synchroniser: a change counts once stages two and three agree
      for (int i = 0; i < 8; i++)
      begin
         if (st.pin_s2[i] == st.pin_s3[i])
            next_st.port_a_pins[i] = st.pin_s3[i];
      end
      // condition bit is caught by a clock edge after any reset, never by the reset
      if (st.cond_load)
         next_st.oscillator_control[`RIV_OSC_COND_BIT] = osc_cond; // RL9

      // apb: one wait cycle, answer registered, write lands at the pready edge
      next_st.pready = psel & penable & ~st.pready;
      next_st.pslverr = 1'b0;
      if (psel & penable & ~st.pready)
      begin
         next_st.prdata = '0; // RL7
         if (paddr == `RIV_OFF_BANK_SELECT)
            next_st.prdata[3:0] = st.bank_select;
         else if (paddr == `RIV_OFF_TMR0_HIGH)
            next_st.prdata[7:0] = st.timer0_high_byte;
         else if (paddr == `RIV_OFF_TMR0_CTRL)
            next_st.prdata[7:0] = st.timer0_control;
         else if (paddr == `RIV_OFF_LVD_CTRL)
            next_st.prdata[5:0] = st.low_voltage_detect_control;
         else if (paddr == `RIV_OFF_WDT_SOFT)
            next_st.prdata[0] = st.watchdog_soft_enable;
         else if (paddr == `RIV_OFF_TMR1_CTRL)
            next_st.prdata[7:0] = st.timer1_control;
         else if (paddr == `RIV_OFF_TIMER2_COUNT_COUNT)
            next_st.prdata[7:0] = st.timer2_count;
         else if (paddr == `RIV_OFF_TIMER2_COUNT_PERIOD)
            next_st.prdata[7:0] = st.timer2_period;
         else if (paddr == `RIV_OFF_TIMER2_COUNT_CTRL)
            next_st.prdata[6:0] = st.timer2_control;
         else if (paddr == `RIV_OFF_SSP_ADDR)
            next_st.prdata[7:0] = st.sync_serial_addr_baud;
         else if (paddr == `RIV_OFF_SSP_STATE)
            next_st.prdata[7:0] = st.sync_serial_state;
         else if (paddr == `RIV_OFF_SSP_CTRL1)
            next_st.prdata[7:0] = st.sync_serial_control_1;
         else if (paddr == `RIV_OFF_SSP_CTRL2)
            next_st.prdata[7:0] = st.sync_serial_control_2;
         else if (paddr == `RIV_OFF_STACK_UPPER)
            next_st.prdata[4:0] = st.stack_top_upper;
         else if (paddr == `RIV_OFF_STACK_HIGH)
            next_st.prdata[7:0] = st.stack_top_high;
         else if (paddr == `RIV_OFF_STACK_LOW)
            next_st.prdata[7:0] = st.stack_top_low;
         else if (paddr == `RIV_OFF_STACK_PTR)
            next_st.prdata[7:0] = {st.stk_full, st.stk_unf, 1'b0, st.stk_ptr}; // RL7
         else if (paddr == `RIV_OFF_INT_CTRL)
            next_st.prdata[7:0] = st.interrupt_control_regs;
         else if (paddr == `RIV_OFF_PERIPH_FLAG)
            next_st.prdata[7:0] = st.peripheral_flag_regs;
         else if (paddr == `RIV_OFF_PORT_A_PINS_LATCH)
            next_st.prdata[7:0] = st.port_a_output_latch & pa_mask; // RL6
         else if (paddr == `RIV_OFF_PORT_A_PINS_DIR)
            next_st.prdata[7:0] = st.port_a_direction & pa_mask; // RL6
         else if (paddr == `RIV_OFF_PORT_A_PINS_PINS)
            next_st.prdata[7:0] = st.port_a_pins & pa_mask; // RL6
         else if (paddr == `RIV_OFF_RESET_CAUSE)
            next_st.prdata[4:0] = st.reset_cause_register;
         else if (paddr == `RIV_OFF_OSC_CTRL)
            next_st.prdata[7:0] = st.oscillator_control;
         else if (paddr == `RIV_OFF_IRQ_STATUS)
            next_st.prdata[3:0] = st.irq_status;
         else if (paddr == `RIV_OFF_IRQ_MASK)
            next_st.prdata[3:0] = st.irq_mask;
         else
            next_st.pslverr = 1'b1;
      end

      // register writes; the condition bit is hardware-owned and ignores software
      if (wr)
      begin
         if (paddr == `RIV_OFF_BANK_SELECT)
            next_st.bank_select = pwdata[3:0];
         else if (paddr == `RIV_OFF_TMR0_HIGH)
            next_st.timer0_high_byte = pwdata[7:0];
         else if (paddr == `RIV_OFF_TMR0_CTRL)
            next_st.timer0_control = pwdata[7:0];
         else if (paddr == `RIV_OFF_LVD_CTRL)
            next_st.low_voltage_detect_control = pwdata[5:0];
         else if (paddr == `RIV_OFF_WDT_SOFT)
            next_st.watchdog_soft_enable = pwdata[0];
         else if (paddr == `RIV_OFF_TMR1_CTRL)
            next_st.timer1_control = pwdata[7:0];
         else if (paddr == `RIV_OFF_TIMER2_COUNT_COUNT)
            next_st.timer2_count = pwdata[7:0];
         else if (paddr == `RIV_OFF_TIMER2_COUNT_PERIOD)
            next_st.timer2_period = pwdata[7:0];
         else if (paddr == `RIV_OFF_TIMER2_COUNT_CTRL)
            next_st.timer2_control = pwdata[6:0];
         else if (paddr == `RIV_OFF_SSP_ADDR)
            next_st.sync_serial_addr_baud = pwdata[7:0];
         else if (paddr == `RIV_OFF_SSP_STATE)
            next_st.sync_serial_state = pwdata[7:0];
         else if (paddr == `RIV_OFF_SSP_CTRL1)
            next_st.sync_serial_control_1 = pwdata[7:0];
         else if (paddr == `RIV_OFF_SSP_CTRL2)
            next_st.sync_serial_control_2 = pwdata[7:0];
         else if (paddr == `RIV_OFF_STACK_UPPER)
            next_st.stack_top_upper = pwdata[4:0];
         else if (paddr == `RIV_OFF_STACK_HIGH)
            next_st.stack_top_high = pwdata[7:0];
         else if (paddr == `RIV_OFF_STACK_LOW)
            next_st.stack_top_low = pwdata[7:0];
         else if (paddr == `RIV_OFF_STACK_PTR)
            {next_st.stk_full, next_st.stk_unf, next_st.stk_ptr} = {pwdata[7:6], pwdata[4:0]};
         else if (paddr == `RIV_OFF_INT_CTRL)
            next_st.interrupt_control_regs = pwdata[7:0];
         else if (paddr == `RIV_OFF_PERIPH_FLAG)
            next_st.peripheral_flag_regs = pwdata[7:0];
         else if (paddr == `RIV_OFF_PORT_A_PINS_LATCH)
            next_st.port_a_output_latch = pwdata[7:0] & pa_mask; // RL5
         else if (paddr == `RIV_OFF_PORT_A_PINS_DIR)
            next_st.port_a_direction = pwdata[7:0] | ~pa_mask; // RL5
         else if (paddr == `RIV_OFF_RESET_CAUSE)
            next_st.reset_cause_register = pwdata[4:0];
         else if (paddr == `RIV_OFF_OSC_CTRL)
            next_st.oscillator_control = {pwdata[7:4], next_st.oscillator_control[3], pwdata[2:0]};
         else if (paddr == `RIV_OFF_IRQ_STATUS)
            next_st.irq_status = st.irq_status & ~pwdata[3:0];
         else if (paddr == `RIV_OFF_IRQ_MASK)
            next_st.irq_mask = pwdata[3:0];
      end

      // brown-out and warm reset classes: fixed defaults except the kept fields, cause bits per source
      if (cause == RIV_CAUSE_BOR)
      begin
         next_st = POR_ST;
         next_st.stk_full = st.stk_full;
         next_st.stk_unf = st.stk_unf;
         next_st.reset_cause_register = st.reset_cause_register;
         next_st.reset_cause_register[`RIV_RC_RI] = 1'b1; // RL8
         next_st.reset_cause_register[`RIV_RC_TO] = 1'b1;
         next_st.reset_cause_register[`RIV_RC_PD] = 1'b1;
         next_st.reset_cause_register[`RIV_RC_BOR] = 1'b0;
      end
      else if (cause != RIV_CAUSE_NONE)
      begin
         next_st = POR_ST;
         next_st.timer0_high_byte = '0;
         next_st.timer1_control = st.timer1_control;
         next_st.timer1_control[`RIV_TMR1_CLR_BIT] = 1'b0;
         next_st.interrupt_control_regs[0] = st.interrupt_control_regs[0];
         next_st.stk_full = st.stk_full;
         next_st.stk_unf = st.stk_unf;
         next_st.irq_status = st.irq_status;
         next_st.irq_mask = st.irq_mask;
         next_st.port_a_pins = st.port_a_pins;
         next_st.reset_cause_register = st.reset_cause_register; // RL8
         case (cause)
            RIV_CAUSE_PIN:
            begin
               next_st.reset_cause_register[`RIV_RC_TO] = 1'b1;
               if (sleeping)
                  next_st.reset_cause_register[`RIV_RC_PD] = 1'b0;
            end
            RIV_CAUSE_WDT: next_st.reset_cause_register[`RIV_RC_TO] = 1'b0;
            RIV_CAUSE_INSTR: next_st.reset_cause_register[`RIV_RC_RI] = 1'b0;
            RIV_CAUSE_STKF: next_st.stk_full = 1'b1;
            RIV_CAUSE_STKU: next_st.stk_unf = 1'b1;
            default: next_st.reset_cause_register = st.reset_cause_register;
         endcase
         next_st.irq_status[`RIV_IS_WARM] = 1'b1;
      end
      else if (sleeping & (wake_wdt_req | wake_irq_req))
      begin
         // wake-up: keep contents, reload timer 2 period, refresh condition bit
         next_st.timer2_period = `RIV_RST_TIMER2_COUNT_PERIOD; // RL10
         next_st.oscillator_control[`RIV_OSC_COND_BIT] = osc_cond; // RL9
         next_st.reset_cause_register[`RIV_RC_PD] = 1'b0; // RL8
         if (wake_wdt_req)
         begin
            next_st.reset_cause_register[`RIV_RC_TO] = 1'b0;
            next_st.irq_status[`RIV_IS_WAKE_WDT] = 1'b1;
         end
         else
         begin
            next_st.peripheral_flag_regs = next_st.peripheral_flag_regs | wake_irq_flags; // RL1
            if (vec_wake)
            begin
               next_st.pc_load_valid = 1'b1;
               next_st.pc_load_value = wake_irq_high ? `RIV_VEC_HIGH : `RIV_VEC_LOW; // RL2
               next_st.stack_top_upper = pc_now[20:16]; // RL3
               next_st.stack_top_high = pc_now[15:8];
               next_st.stack_top_low = pc_now[7:0];
               next_st.stk_ptr = st.stk_ptr + 5'h01; // RL4
               if (st.stk_ptr == 5'h1f)
               begin
                  next_st.stk_full = 1'b1;
                  next_st.irq_status[`RIV_IS_STACK_FULL] = 1'b1;
               end
               next_st.irq_status[`RIV_IS_WAKE_VEC] = 1'b1;
            end
         end
      end

      // synchroniser stages shift through brown-out and warm resets; outputs follow settled values
      next_st.pin_s1 = port_a_pin_in;
      next_st.pin_s2 = st.pin_s1;
      next_st.pin_s3 = st.pin_s2;
      next_st.port_a_out = next_st.port_a_output_latch & pa_mask; // RL5
      next_st.port_a_oe = ~next_st.port_a_direction & pa_mask; // RL6
      next_st.irq = |(next_st.irq_status & next_st.irq_mask);
   end

   // single state register; async reset loads power-on constants only
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         st <= POR_ST;
      else
         st <= next_st;
   end

   assign pready = st.pready;
   assign pslverr = st.pslverr;
   assign prdata = st.prdata;
   assign irq = st.irq;
   assign pc_load_valid = st.pc_load_valid;
   assign pc_load_value = st.pc_load_value;
   assign port_a_out = st.port_a_out;
   assign port_a_oe = st.port_a_oe;

   // checks on the wake-up and reset behaviour
   chk_wake_flags: assert property (@(posedge mclk) disable iff (!rst_n) // RL1
      (sleeping && wake_irq_req && !wake_wdt_req && cause == RIV_CAUSE_NONE)
      |=> ((st.peripheral_flag_regs & $past(wake_irq_flags)) == $past(wake_irq_flags)))
      else $error("wake flags not recorded");
   chk_vector_load: assert property (@(posedge mclk) disable iff (!rst_n) // RL2
      pc_load_valid |-> (pc_load_value == (($past(wake_irq_high)) ? `RIV_VEC_HIGH
      : `RIV_VEC_LOW)))
      else $error("wrong interrupt vector");
   chk_stack_top: assert property (@(posedge mclk) disable iff (!rst_n) // RL3
      pc_load_valid |-> ({st.stack_top_upper, st.stack_top_high, st.stack_top_low}
      == $past(pc_now)))
      else $error("stack top not loaded from pc");
   chk_stack_ptr: assert property (@(posedge mclk) disable iff (!rst_n) // RL4
      pc_load_valid |-> (st.stk_ptr == 5'($past(st.stk_ptr) + 5'h01)))
      else $error("stack pointer not advanced");
   chk_port_a_pins_hi: assert property (@(posedge mclk) disable iff (!rst_n) // RL5
      (!osc_frees_port_a_pins_hi && !$past(osc_frees_port_a_pins_hi)) |-> (port_a_oe[7:6] == 2'b00
      && port_a_out[7:6] == 2'b00))
      else $error("disabled port a bits driven");
   chk_port_a_pins_read: assert property (@(posedge mclk) disable iff (!rst_n) // RL6
      (psel && penable && !pready && !osc_frees_port_a_pins_hi
      && paddr == `RIV_OFF_PORT_A_PINS_PINS) |=> (prdata[7:6] == 2'b00))
      else $error("disabled port a bits read nonzero");
   chk_unimpl_zero: assert property (@(posedge mclk) disable iff (!rst_n) // RL7
      (psel && penable && !pready && paddr == `RIV_OFF_STACK_PTR)
      |=> (prdata[31:8] == 24'h000000 && prdata[5] == 1'b0))
      else $error("unimplemented bits read nonzero");
   chk_cause_wdt: assert property (@(posedge mclk) disable iff (!rst_n) // RL8
      (cause == RIV_CAUSE_WDT) |=> (!st.reset_cause_register[`RIV_RC_TO]
      && st.reset_cause_register[`RIV_RC_RI] == $past(st.reset_cause_register[`RIV_RC_RI])))
      else $error("watchdog cause bits wrong");
   chk_osc_cond: assert property (@(posedge mclk) disable iff (!rst_n) // RL9
      (cause != RIV_CAUSE_NONE) |=> ##1 (st.oscillator_control[`RIV_OSC_COND_BIT]
      == $past(osc_cond)))
      else $error("condition bit not loaded");
   chk_period_wake: assert property (@(posedge mclk) disable iff (!rst_n) // RL10
      (sleeping && (wake_wdt_req || wake_irq_req) && cause == RIV_CAUSE_NONE)
      |=> (st.timer2_period == `RIV_RST_TIMER2_COUNT_PERIOD && st.bank_select == $past(st.bank_select)))
      else $error("wake-up register handling wrong");
endmodule // riv_top

// *** bench/reset_init_values_tb_top.sv ***
// reset_init_values_tb_top: apb bench for the reset and wake-up init block.
// assumes riv_consts.svh offsets and a registered pready in the access phase.
`timescale 1ns/1ps
`include "riv_consts.svh"
module reset_init_values_tb_top;
   logic mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, err, hi;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rdat;
   logic pready, pslverr, irq, pc_load_valid, sleeping = 0, osc_cond = 1, osc_free = 1;
   logic bor = 0, pin_rst = 0, wdt_rst = 0, instr_rst = 0, full_rst = 0, unf_rst = 0;
   logic wake_wdt = 0, wake_irq = 0, wake_hi = 0;
   logic [20:0] pc_now = 21'h012345, pc_load_value;
   logic [7:0] flags = 8'h5a, pins = 8'hff, port_a_out, port_a_oe;
   int fail_count = 0, checks_done = 0;
   // free-running 50 MHz clock
   always #10 mclk = ~mclk;
   riv_top riv_top_i (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
      .prdata(prdata), .irq(irq), .bor_req(bor), .pin_reset_req(pin_rst),
      .wdt_reset_req(wdt_rst), .reset_instr_req(instr_rst), .stk_full_req(full_rst),
      .stk_unf_req(unf_rst), .sleeping(sleeping), .wake_wdt_req(wake_wdt),
      .wake_irq_req(wake_irq), .wake_irq_high(wake_hi), .wake_irq_flags(flags),
      .pc_now(pc_now), .osc_cond(osc_cond), .osc_frees_port_a_pins_hi(osc_free),
      .port_a_pin_in(pins), .pc_load_valid(pc_load_valid), .pc_load_value(pc_load_value),
      .port_a_out(port_a_out), .port_a_oe(port_a_oe));
   task automatic close_out;
      if (fail_count == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
         fail_count++;
      end
   endtask
   // one apb transfer; the master never assumes a latency, it waits for pready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rdat = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rdat, exp);
   endtask
   // one-cycle pulse on the request line picked by k, lines listed from bit 6 down
   task automatic pulse(input int k);
      @(posedge mclk);
      {bor, pin_rst, wdt_rst, instr_rst, full_rst, unf_rst, wake_wdt} <= 7'(1 << k);
      @(posedge mclk);
      {bor, pin_rst, wdt_rst, instr_rst, full_rst, unf_rst, wake_wdt} <= 7'h00;
   endtask
   // hang guard, far beyond the few hundred cycles the sequence needs
   initial
   begin
      repeat (4000) @(posedge mclk);
      fail_count++;
      close_out();
   end
   initial
   begin
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      rd(`RIV_OFF_TMR0_CTRL, 32'hff);
      rd(`RIV_OFF_LVD_CTRL, 32'h05);
      rd(`RIV_OFF_PORT_A_PINS_DIR, 32'hff);
      rd(`RIV_OFF_RESET_CAUSE, 32'h1c);
      rd(`RIV_OFF_OSC_CTRL, 32'h08);
      apb(1'b1, `RIV_OFF_BANK_SELECT, 32'hffffffff);
      rd(`RIV_OFF_BANK_SELECT, 32'h0000000f);
      rd(12'hffc, 32'h0);
      chk({31'h0, err}, 32'h1);
      rd(`RIV_OFF_PORT_A_PINS_PINS, 32'hff);
      apb(1'b1, `RIV_OFF_PORT_A_PINS_DIR, 32'h0);
      rd(`RIV_OFF_PORT_A_PINS_DIR, 32'h0);
      chk({24'h0, port_a_oe}, 32'hff);
      osc_free <= 1'b0;
      rd(`RIV_OFF_PORT_A_PINS_PINS, 32'h3f);
      chk({24'h0, port_a_oe}, 32'h3f);
      apb(1'b1, `RIV_OFF_PORT_A_PINS_LATCH, 32'hff);
      rd(`RIV_OFF_PORT_A_PINS_LATCH, 32'h3f);
      chk({24'h0, port_a_out}, 32'h3f);
      apb(1'b1, `RIV_OFF_IRQ_MASK, 32'h4);
      // high then low priority vectored wake, both from sleep
      for (int i = 0; i < 2; i++)
      begin
         hi = (i == 0);
         apb(1'b1, `RIV_OFF_INT_CTRL, hi ? 32'h80 : 32'h40);
         apb(1'b1, `RIV_OFF_TIMER2_COUNT_PERIOD, 32'h12);
         @(posedge mclk);
         sleeping <= 1'b1;
         wake_hi <= hi;
         wake_irq <= 1'b1;
         @(posedge mclk);
         wake_irq <= 1'b0;
         #1;
         chk({31'h0, pc_load_valid}, 32'h1);
         chk({11'h0, pc_load_value}, hi ? 32'h8 : 32'h18);
         rd(`RIV_OFF_STACK_UPPER, 32'h01);
         rd(`RIV_OFF_STACK_HIGH, 32'h23);
         rd(`RIV_OFF_STACK_LOW, 32'h45);
         rd(`RIV_OFF_STACK_PTR, i + 1);
         rd(`RIV_OFF_PERIPH_FLAG, 32'h5a);
         rd(`RIV_OFF_TIMER2_COUNT_PERIOD, 32'hff);
         rd(`RIV_OFF_BANK_SELECT, 32'h0f);
      end
      rd(`RIV_OFF_RESET_CAUSE, 32'h18);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, `RIV_OFF_IRQ_STATUS, 32'h4);
      rd(`RIV_OFF_IRQ_STATUS, 32'h0);
      chk({31'h0, irq}, 32'h0);
      // watchdog reset at full power clears only the timeout bit of the cause
      sleeping <= 1'b0;
      osc_cond <= 1'b0;
      pulse(4);
      rd(`RIV_OFF_RESET_CAUSE, 32'h10);
      rd(`RIV_OFF_BANK_SELECT, 32'h0);
      rd(`RIV_OFF_OSC_CTRL, 32'h0);
      // the other warm causes, a watchdog wake from sleep, then a mid-run power-on reset
      pulse(3);
      rd(`RIV_OFF_RESET_CAUSE, 32'h00);
      sleeping <= 1'b1;
      pulse(5);
      rd(`RIV_OFF_RESET_CAUSE, 32'h08);
      pulse(0);
      rd(`RIV_OFF_RESET_CAUSE, 32'h00);
      rd(`RIV_OFF_IRQ_STATUS, 32'h3);
      sleeping <= 1'b0;
      pulse(2);
      pulse(1);
      rd(`RIV_OFF_STACK_PTR, 32'hc0);
      pulse(6);
      rd(`RIV_OFF_RESET_CAUSE, 32'h1c);
      rd(`RIV_OFF_STACK_PTR, 32'hc0);
      osc_cond <= 1'b1;
      @(posedge mclk);
      rst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      rd(`RIV_OFF_STACK_PTR, 32'h0);
      rd(`RIV_OFF_OSC_CTRL, 32'h08);
      close_out();
   end
endmodule // reset_init_values_tb_top
